// *** verilog/escr_consts.vh ***
`ifndef ESCR_CONSTS_VH
`define ESCR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, 12-bit window)
// ----------------------------------------------------------------------
`define ESCR_ADDR_W          12
`define ESCR_OFF_ICS         12'h000
`define ESCR_OFF_VTBO        12'h004
`define ESCR_OFF_AIRC        12'h008

// ----------------------------------------------------------------------
// Interrupt control and state fields
// ----------------------------------------------------------------------
`define ESCR_PEND_HI         20
`define ESCR_PEND_LO         12
`define ESCR_RTB_BIT         11
`define ESCR_ACT_HI          8
`define ESCR_ACT_LO          0

// ----------------------------------------------------------------------
// Vector table offset fields
// ----------------------------------------------------------------------
`define ESCR_TBL_LSB         7
`define ESCR_VTBO_RESET      32'h00000000

// ----------------------------------------------------------------------
// Application interrupt and reset control fields
// ----------------------------------------------------------------------
`define ESCR_KEY_HI          31
`define ESCR_KEY_LO          16
`define ESCR_KEY_WRITE       16'h05FA
`define ESCR_KEY_READ        16'hFA05
`define ESCR_ENDIAN_BIT      15
`define ESCR_ENDIAN_VAL      1'b0
`define ESCR_GRP_HI          10
`define ESCR_GRP_LO          8
`define ESCR_GRP_RESET       3'h0
`define ESCR_SRST_BIT        2

// ----------------------------------------------------------------------
// Exception model sizes
// ----------------------------------------------------------------------
`define ESCR_NUM_EXC         32
`define ESCR_PRIO_W          8

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define ESCR_RESP_OKAY       2'h0
`define ESCR_RESP_SLVERR     2'h2

`endif

// *** verilog/escr_prio_pick.v ***
`timescale 1ns/1ns
`default_nettype none
`include "escr_consts.vh"

module escr_prio_pick
(
  // Exception state
  input  wire [`ESCR_NUM_EXC-1:0]               exc_pending,
  input  wire [`ESCR_NUM_EXC-1:0]               exc_enabled,
  input  wire [`ESCR_NUM_EXC*`ESCR_PRIO_W-1:0]  exc_priority,
  // Masking
  input  wire [`ESCR_PRIO_W-1:0]                base_priority_mask,
  input  wire                                   fault_mask_reg,
  // Result
  output reg  [8:0]                             pick_num
);

  wire [`ESCR_NUM_EXC-1:0] eligible;
  wire [8:0]               rank [0:`ESCR_NUM_EXC-1];

  // ----------------------------------------------------------------------
  // Per-exception eligibility and sort key
  // ----------------------------------------------------------------------
  // Numbers 1..3 carry fixed ranks below every programmable priority
  genvar gi;
  generate
    for (gi = 0; gi < `ESCR_NUM_EXC; gi = gi + 1)
    begin : g_exc
      wire [`ESCR_PRIO_W-1:0] pr = exc_priority[gi*`ESCR_PRIO_W +: `ESCR_PRIO_W];
      wire                    fixed = (gi >= 1) && (gi <= 3);
      wire                    bp_mask = (base_priority_mask != 8'h00) && !fixed &&
                                        (pr >= base_priority_mask);  // RULE2
      wire                    fm_mask = fault_mask_reg && (gi >= 3);   // RULE2
      assign eligible[gi] = (gi != 0) && exc_pending[gi] && exc_enabled[gi] &&
                            !bp_mask && !fm_mask;                      // RULE1
      assign rank[gi] = !fixed ? {1'b1, pr} :
                        (gi == 1) ? 9'h000 : (gi == 2) ? 9'h001 : 9'h002;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Lowest key wins, ties go to the lower number; zero when none
  // ----------------------------------------------------------------------
  integer    i;
  reg  [8:0] best;
  always @*
  begin
    best     = 9'h1FF;
    pick_num = 9'h000;
    for (i = 0; i < `ESCR_NUM_EXC; i = i + 1)
    begin
      if (eligible[i] && ((pick_num == 9'h000) || (rank[i] < best)))
      begin
        best     = rank[i];
        pick_num = i[8:0];                                             // RULE1
      end
    end
  end

endmodule // escr_prio_pick
`default_nettype wire

// *** verilog/escr_regs.v ***
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "escr_consts.vh"

// Behaviour
// RULE1 - Bits 20:12 give highest-priority pending enabled exception, zero if none.
// RULE2 - Pending choice honours base priority and fault mask, ignores priority mask.
// RULE3 - Bit 11 low while preempted actives remain, high otherwise.
// RULE4 - Bits 8:0 give active exception number, zero in thread mode.
// RULE5 - Active field always equals low nine bits of program status word.
// RULE6 - Software never sets pend-set and pend-clear together for one exception.
// RULE7 - Table offset register holds offset in 31:7; 6:0 reserved.
// RULE8 - Lowest implemented offset bit is fixed; bits below it not writable.
// RULE9 - Software aligns table offset to 32 words or next power of two.
// RULE10 - Table offset bits 6:0 always read zero.
// RULE11 - Reset control writes without key 0x5FA are discarded.
// RULE12 - Reset control bit 15 reads fixed byte order, zero little-endian.
// RULE13 - Keyed write of one to bit 2 raises system reset request; reads zero.
// RULE14 - Reserved bits read zero and ignore writes.
// RULE15 - Status fields follow exception state within one clock.
module escr_regs
(
  // Clock and reset
  input  wire                                   aclk,
  input  wire                                   aresetn,
  // AXI4-Lite write address
  input  wire [`ESCR_ADDR_W-1:0]                s_axi_awaddr,
  input  wire [2:0]                             s_axi_awprot,
  input  wire                                   s_axi_awvalid,
  output wire                                   s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]                            s_axi_wdata,
  input  wire [3:0]                             s_axi_wstrb,
  input  wire                                   s_axi_wvalid,
  output wire                                   s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]                             s_axi_bresp,
  output reg                                    s_axi_bvalid,
  input  wire                                   s_axi_bready,
  // AXI4-Lite read address
  input  wire [`ESCR_ADDR_W-1:0]                s_axi_araddr,
  input  wire [2:0]                             s_axi_arprot,
  input  wire                                   s_axi_arvalid,
  output wire                                   s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]                            s_axi_rdata,
  output reg  [1:0]                             s_axi_rresp,
  output reg                                    s_axi_rvalid,
  input  wire                                   s_axi_rready,
  // Exception state from the core
  input  wire [`ESCR_NUM_EXC-1:0]               exc_pending,
  input  wire [`ESCR_NUM_EXC-1:0]               exc_enabled,
  input  wire [`ESCR_NUM_EXC-1:0]               exc_active,
  input  wire [`ESCR_NUM_EXC*`ESCR_PRIO_W-1:0]  exc_priority,
  input  wire [8:0]                             interrupt_program_status_word,
  // Masking registers from the core
  input  wire [`ESCR_PRIO_W-1:0]                base_priority_mask,
  input  wire                                   fault_mask_reg,
  input  wire                                   priority_mask_reg,
  // Outputs to the core and system
  output wire [31:0]                            vector_table_base,
  output wire [2:0]                             priority_group,
  output reg                                    system_reset_request
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  localparam [1:0] SEL_ICS  = 2'h0;
  localparam [1:0] SEL_VTBO = 2'h1;
  localparam [1:0] SEL_AIRC = 2'h2;
  localparam [1:0] SEL_NONE = 2'h3;

  // Shared by the read and the write path
  function [1:0] reg_sel;
    input [`ESCR_ADDR_W-1:0] addr;
    begin
      case (addr)
        `ESCR_OFF_ICS:  reg_sel = SEL_ICS;
        `ESCR_OFF_VTBO: reg_sel = SEL_VTBO;
        `ESCR_OFF_AIRC: reg_sel = SEL_AIRC;
        default:        reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Stored registers
  // ----------------------------------------------------------------------
  reg  [31:0] vtbo_q;
  reg  [31:0] vtbo_d;
  reg  [2:0]  grp_q;
  reg  [2:0]  grp_d;
  reg         srst_d;

  // Writable mask of the table offset: bits below the fixed LSB stay zero
  localparam [31:0] VTBO_WMASK = 32'hFFFFFFFF << `ESCR_TBL_LSB;          // RULE8

  assign vector_table_base = vtbo_q;
  assign priority_group    = grp_q;

  // ----------------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------------
  wire [8:0] pick_num;
  reg  [8:0] pend_num_q;
  reg        rtb_q;
  reg        rtb_d;

  escr_prio_pick u_pick
  (
    .exc_pending        (exc_pending),
    .exc_enabled        (exc_enabled),
    .exc_priority       (exc_priority),
    .base_priority_mask (base_priority_mask),
    .fault_mask_reg     (fault_mask_reg),
    .pick_num           (pick_num)
  );

  // Priority mask is deliberately left out of the pending choice
  wire unused_prio_mask = priority_mask_reg;                              // RULE2

  // More than one active means a preempted handler waits below the current one
  integer    k;
  reg  [5:0] act_cnt;
  always @*
  begin
    act_cnt = 6'h00;
    for (k = 0; k < `ESCR_NUM_EXC; k = k + 1)
    begin
      act_cnt = act_cnt + {5'h00, exc_active[k]};
    end
    rtb_d = (act_cnt <= 6'h01);                                           // RULE3
  end

  // One clock of latency keeps the decode off the bus read path
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_num_q <= 9'h000;
      rtb_q      <= 1'b1;
    end
    else
    begin
      pend_num_q <= pick_num;                                             // RULE15
      rtb_q      <= rtb_d;                                                // RULE15
    end
  end

  // ----------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  reg  [`ESCR_ADDR_W-1:0] aw_addr_q;
  reg                     aw_held_q;
  reg  [31:0]             w_data_q;
  reg  [3:0]              w_strb_q;
  reg                     w_held_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  wire                    aw_fire = s_axi_awvalid && s_axi_awready;
  wire                    w_fire  = s_axi_wvalid && s_axi_wready;
  wire                    aw_have = aw_held_q || aw_fire;
  wire                    w_have  = w_held_q || w_fire;
  wire                    wr_go   = aw_have && w_have;
  wire [`ESCR_ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0]             wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0]              wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire [1:0]              wr_sel  = reg_sel(wr_addr);

  // Byte lanes expanded to a bit mask
  wire [31:0] lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Key must arrive whole in the upper lanes or the write is dropped
  wire key_ok = (wr_strb[3:2] == 2'h3) &&
                (wr_data[`ESCR_KEY_HI:`ESCR_KEY_LO] == `ESCR_KEY_WRITE);  // RULE11

  // Next values of the stored fields
  always @*
  begin
    vtbo_d = vtbo_q;
    grp_d  = grp_q;
    srst_d = system_reset_request;
    if (wr_go)
    begin
      case (wr_sel)
        SEL_VTBO:
        begin
          // Reserved low bits and bits under the LSB never take a value
          vtbo_d = (vtbo_q & ~(lane_mask & VTBO_WMASK)) |
                   (wr_data & lane_mask & VTBO_WMASK);                    // RULE7 RULE10
        end
        SEL_AIRC:
        begin
          if (key_ok && wr_strb[1])                                       // RULE11
          begin
            grp_d = wr_data[`ESCR_GRP_HI:`ESCR_GRP_LO];
          end
          if (key_ok && wr_strb[0] && wr_data[`ESCR_SRST_BIT])            // RULE11
          begin
            srst_d = 1'b1;                                                // RULE13
          end
        end
        default:
        begin
          // Control and state register and unmapped words: nothing stored
          vtbo_d = vtbo_q;                                                // RULE14
        end
      endcase
    end
  end

  // Write side registers; the reset request holds until system reset
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q            <= {`ESCR_ADDR_W{1'b0}};
      aw_held_q            <= 1'b0;
      w_data_q             <= 32'h00000000;
      w_strb_q             <= 4'h0;
      w_held_q             <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `ESCR_RESP_OKAY;
      vtbo_q               <= `ESCR_VTBO_RESET;
      grp_q                <= `ESCR_GRP_RESET;
      system_reset_request <= 1'b0;
    end
    else
    begin
      vtbo_q               <= vtbo_d;
      grp_q                <= grp_d;
      system_reset_request <= srst_d;
      if (aw_fire && !wr_go)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
      end
      else if (wr_go)
      begin
        aw_held_q <= 1'b0;
      end
      if (w_fire && !wr_go)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      else if (wr_go)
      begin
        w_held_q <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == SEL_NONE) ? `ESCR_RESP_SLVERR : `ESCR_RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  wire       ar_fire = s_axi_arvalid && s_axi_arready;
  wire [1:0] rd_sel  = reg_sel(s_axi_araddr);

  // Read views; reserved and write-only bits come back zero
  reg  [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h00000000;                                               // RULE14
    case (rd_sel)
      SEL_ICS:
      begin
        rd_word[`ESCR_PEND_HI:`ESCR_PEND_LO] = pend_num_q;                // RULE1
        rd_word[`ESCR_RTB_BIT]               = rtb_q;                     // RULE3
        // Taken straight from the status word so both views always agree
        rd_word[`ESCR_ACT_HI:`ESCR_ACT_LO]   = interrupt_program_status_word; // RULE4 RULE5
      end
      SEL_VTBO:
      begin
        rd_word = vtbo_q & VTBO_WMASK;                                    // RULE10
      end
      SEL_AIRC:
      begin
        rd_word[`ESCR_KEY_HI:`ESCR_KEY_LO] = `ESCR_KEY_READ;
        rd_word[`ESCR_ENDIAN_BIT]          = `ESCR_ENDIAN_VAL;            // RULE12
        rd_word[`ESCR_GRP_HI:`ESCR_GRP_LO] = grp_q;
        rd_word[`ESCR_SRST_BIT]            = 1'b0;                        // RULE13
      end
      default:
      begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Data is sampled at the address handshake and held until taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ESCR_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_sel == SEL_NONE) ? `ESCR_RESP_SLVERR : `ESCR_RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Protection bits carry no meaning for this block
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, unused_prio_mask};

endmodule // escr_regs
`default_nettype wire

// *** bench/escr_regs_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "escr_consts.vh"

// ------------------------------------------------------------
// Register bank checker
// ------------------------------------------------------------
module escr_regs_sva
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus side
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  // Core side
  input wire logic [8:0]  interrupt_program_status_word,
  input wire logic [31:0] vector_table_base,
  input wire logic [2:0]  priority_group,
  input wire logic        system_reset_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Only writes offered on both channels at once are judged here
  wire logic        wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic        ar_go  = s_axi_arvalid && s_axi_arready;
  wire logic        key_ok = s_axi_wdata[31:16] == 16'h05FA;
  wire logic        full   = s_axi_wstrb == 4'hF;
  wire logic [2:0]  w_grp  = s_axi_wdata[10:8];
  wire logic [24:0] w_tbl  = s_axi_wdata[31:7];

  property p_vtb_low; vector_table_base[6:0] == 7'h00; endproperty
  a_vtb_low: assert property (p_vtb_low)
    else $error("table offset low bits not zero");
  property p_srst_hold; system_reset_request |=> system_reset_request; endproperty
  a_srst_hold: assert property (p_srst_hold)
    else $error("reset request dropped");
  property p_srst_set;
    wr_go && s_axi_awaddr == 12'h008 && key_ok && full && s_axi_wdata[2] |=> system_reset_request;
  endproperty
  a_srst_set: assert property (p_srst_set)
    else $error("keyed reset request not raised");
  property p_bad_key;
    wr_go && s_axi_awaddr == 12'h008 && !key_ok |=> $stable(priority_group)
      && !$rose(system_reset_request);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("unkeyed write took effect");
  property p_good_key;
    wr_go && s_axi_awaddr == 12'h008 && key_ok && full |=> priority_group == $past(w_grp);
  endproperty
  a_good_key: assert property (p_good_key)
    else $error("keyed write lost");
  property p_vtb_write;
    wr_go && s_axi_awaddr == 12'h004 && full |=> vector_table_base == {$past(w_tbl), 7'h00};
  endproperty
  a_vtb_write: assert property (p_vtb_write)
    else $error("table offset write wrong");
  property p_ics_read;
    ar_go && s_axi_araddr == 12'h000 |=> s_axi_rdata[8:0] == $past(interrupt_program_status_word)
      && s_axi_rdata[31:21] == 11'h000 && s_axi_rdata[10:9] == 2'h0;
  endproperty
  a_ics_read: assert property (p_ics_read)
    else $error("status read wrong");
  property p_airc_read;
    ar_go && s_axi_araddr == 12'h008 |=> s_axi_rdata[31:11] == 21'h1F40A0
      && s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[10:8] == $past(priority_group);
  endproperty
  a_airc_read: assert property (p_airc_read)
    else $error("reset control read wrong");
endmodule // escr_regs_sva

bind escr_regs escr_regs_sva chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .interrupt_program_status_word, .vector_table_base,
  .priority_group, .system_reset_request);
`default_nettype wire

// *** bench/exception_status_vector_base_regs_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "escr_consts.vh"

module exception_status_vector_base_regs_bench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         aclk = 1'h0;
  logic         aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         fault_mask_reg, priority_mask_reg, system_reset_request;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [2:0]   priority_group;
  logic [3:0]   s_axi_wstrb;
  logic [7:0]   base_priority_mask;
  logic [8:0]   interrupt_program_status_word;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, vector_table_base, exc_pending, exc_enabled, exc_active;
  logic [255:0] exc_priority;
  int           errors = 0, n_compared = 0, cycles = 0;

  escr_regs uut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exc_pending, .exc_enabled,
    .exc_active, .exc_priority, .interrupt_program_status_word, .base_priority_mask,
    .fault_mask_reg, .priority_mask_reg, .vector_table_base, .priority_group,
    .system_reset_request
  );

  // ------------------------------------------------------------
  // Clock, timeout and reporting
  // ------------------------------------------------------------
  always #20 aclk = ~aclk;

  // Whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  task complete_run;
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Bus cycles: each channel held until its own ready
  // ------------------------------------------------------------
  task wchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
        break;
    end
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    s_axi_bready <= 1'h0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
        break;
    end
    chk(s_axi_rdata, exp, "read data");
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'h0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Status lags the inputs by a cycle, so two edges pass before reading
  task pend_case(input logic [31:0] p, en, input logic [7:0] bm, input logic fm, pm,
                 input logic [8:0] exp);
    @(posedge aclk);
    exc_pending <= p;
    exc_enabled <= en;
    base_priority_mask <= bm;
    fault_mask_reg <= fm;
    priority_mask_reg <= pm;
    repeat (2) @(posedge aclk);
    rchk(12'h000, {11'h000, exp, 1'h1, 11'h000}, `ESCR_RESP_OKAY);
  endtask

  task act_case(input logic [31:0] act, input logic [8:0] num, input logic rtb);
    @(posedge aclk);
    exc_active <= act;
    interrupt_program_status_word <= num;
    repeat (2) @(posedge aclk);
    rchk(12'h000, {11'h000, 9'h000, rtb, 2'h0, num}, `ESCR_RESP_OKAY);
  endtask

  task t_pending;
    @(posedge aclk);
    exc_priority[5*8 +: 8] <= 8'h40;
    exc_priority[7*8 +: 8] <= 8'h20;
    pend_case(32'h000000A0, 32'hFFFFFFFF, 8'h00, 1'h0, 1'h1, 9'h007);
    pend_case(32'h000000A0, 32'hFFFFFF7F, 8'h00, 1'h0, 1'h0, 9'h005);
    pend_case(32'h000000A0, 32'hFFFFFFFF, 8'h20, 1'h0, 1'h0, 9'h000);
    pend_case(32'h000000A4, 32'hFFFFFFFF, 8'h20, 1'h0, 1'h0, 9'h002);
    pend_case(32'h000000A8, 32'hFFFFFFFF, 8'h00, 1'h1, 1'h0, 9'h000);
    pend_case(32'h000000AC, 32'hFFFFFFFF, 8'h00, 1'h1, 1'h0, 9'h002);
    pend_case(32'h00000240, 32'hFFFFFFFF, 8'h00, 1'h0, 1'h0, 9'h006);
    pend_case(32'h00000084, 32'hFFFFFFFF, 8'h00, 1'h0, 1'h0, 9'h002);
    pend_case(32'h00000000, 32'hFFFFFFFF, 8'h00, 1'h0, 1'h0, 9'h000);
  endtask

  task t_active;
    act_case(32'h00000800, 9'h00B, 1'h1);
    act_case(32'h00008800, 9'h00F, 1'h0);
    act_case(32'h80000000, 9'h01F, 1'h1);
    act_case(32'h00000000, 9'h000, 1'h1);
  endtask

  // Offsets kept aligned to a power-of-two table size
  task t_table;
    wchk(12'h004, 32'h20000100, 4'hF, `ESCR_RESP_OKAY);
    rchk(12'h004, 32'h20000100, `ESCR_RESP_OKAY);
    chk(vector_table_base, 32'h20000100, "table base port");
    wchk(12'h004, 32'hFFFFFFFF, 4'h1, `ESCR_RESP_OKAY);
    rchk(12'h004, 32'h20000180, `ESCR_RESP_OKAY);
  endtask

  // Stray places: unmapped word and writes to the status register
  task t_misc;
    wchk(12'h010, 32'h12345678, 4'hF, `ESCR_RESP_SLVERR);
    rchk(12'h010, 32'h00000000, `ESCR_RESP_SLVERR);
    wchk(12'h000, 32'h00000E00, 4'hF, `ESCR_RESP_OKAY);
    rchk(12'h000, 32'h00000800, `ESCR_RESP_OKAY);
  endtask

  task t_reset_ctrl;
    rchk(12'h008, 32'hFA050000, `ESCR_RESP_OKAY);
    wchk(12'h008, 32'hFA050504, 4'hF, `ESCR_RESP_OKAY);
    rchk(12'h008, 32'hFA050000, `ESCR_RESP_OKAY);
    chk({31'h0, system_reset_request}, 32'h0, "request after bad key");
    wchk(12'h008, 32'h05FA0500, 4'hF, `ESCR_RESP_OKAY);
    chk({29'h0, priority_group}, 32'h5, "group port");
    chk({31'h0, system_reset_request}, 32'h0, "request early");
    wchk(12'h008, 32'h05FA0704, 4'hF, `ESCR_RESP_OKAY);
    rchk(12'h008, 32'hFA050700, `ESCR_RESP_OKAY);
    chk({31'h0, system_reset_request}, 32'h1, "request raised");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    aresetn = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    exc_pending = 32'h0;
    exc_enabled = 32'h0;
    exc_active = 32'h0;
    exc_priority = {32{8'h80}};
    interrupt_program_status_word = 9'h000;
    base_priority_mask = 8'h00;
    fault_mask_reg = 1'h0;
    priority_mask_reg = 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(12'h000, 32'h00000800, `ESCR_RESP_OKAY);
    rchk(12'h004, 32'h00000000, `ESCR_RESP_OKAY);
    t_pending();
    t_active();
    t_table();
    t_misc();
    t_reset_ctrl();
    complete_run();
  end
endmodule // exception_status_vector_base_regs_bench
`default_nettype wire
